//--- core/ixb_defs.vh
// constants for the indexed execute and branch address logic
`ifndef IXB_DEFS_VH
`define IXB_DEFS_VH

// register byte offsets
`define IXB_OFF_INSTR 5'h00
`define IXB_OFF_OPERAND 5'h04
`define IXB_OFF_PC 5'h08
`define IXB_OFF_AR 5'h0C
`define IXB_OFF_STATUS 5'h10
`define IXB_OFF_IVBUS 5'h14

// reset values
`define IXB_RST_ADDR 13'h0000
`define IXB_RST_INSTR 16'h0000
`define IXB_RST_OPERAND 8'h00

// opcodes, instruction bits 15:13
`define IXB_OP_MOVE 3'h0
`define IXB_OP_ADD 3'h1
`define IXB_OP_AND 3'h2
`define IXB_OP_XOR 3'h3
`define IXB_OP_XEC 3'h4
`define IXB_OP_NZT 3'h5
`define IXB_OP_TRANSMIT_LITERAL 3'h6
`define IXB_OP_JMP 3'h7

// field positions
`define IXB_F_OP_HI 15
`define IXB_F_OP_LO 13
`define IXB_F_SRC_HI 12
`define IXB_F_SRC_LO 8
`define IXB_F_BANK_HI 12
`define IXB_F_BANK_LO 11
`define IXB_F_ROT_HI 10
`define IXB_F_ROT_LO 8
`define IXB_F_LEN_HI 7
`define IXB_F_LEN_LO 5
`define IXB_F_JR_HI 7
`define IXB_F_JR_LO 0
`define IXB_F_JB_HI 4
`define IXB_F_JB_LO 0
`define IXB_F_JMP_HI 12
`define IXB_F_JMP_LO 0

// bank select codes
`define IXB_BANK_LEFT 2'h2
`define IXB_BANK_RIGHT 2'h3

// status bit positions
`define IXB_ST_CHAIN 0
`define IXB_ST_TAKEN 1
`define IXB_ST_LATCH_LO 8

`endif

//--- core/ixb_field.v
// rotate right and mask of an interface vector field
`timescale 1ns/10ps
`default_nettype none

module ixb_field (
    // source byte and controls
    input wire [7:0] data,
    input wire [2:0] rotate_position,
    input wire [2:0] length,
    // zero extended field
    output reg [7:0] field
);
    reg [15:0] twice;
    reg [7:0] rotated;
    reg [7:0] mask;

    always @* begin
        twice = {data, data};
        rotated = twice[rotate_position +: 8];
        // length code 0 means a full byte
        if (length == 3'h0) begin
            mask = 8'hFF;
        end else begin
            mask = ~(8'hFF << length);
        end
        field = rotated & mask;
    end
endmodule // ixb_field

`default_nettype wire

//--- core/ixb_core.v
// indexed execute and non-zero branch program address logic with avalon slave
//
// Behaviour
// - Register-sourced indexed_execute puts the 8-bit sum of literal and register in the low 8 address bits.
// - Bus-sourced indexed_execute puts the 5-bit sum of literal and processed field in the low 5 address bits.
// - An indexed_execute never changes the program counter; only its target may.
// - A move, add, logic, transmit_literal or untaken branch target increments the program counter by 1.
// - A jump_instruction or taken branch target loads the program counter with its encoded address.
// - Targets may chain further indexed_execute words at any depth without touching the program counter.
// - A register-sourced sum above 255 keeps its low 8 bits and leaves the overflow untouched.
// - A bus-sourced sum above 31 keeps its low 5 bits and leaves the overflow untouched.
// - The upper 5 address bits fix a 256-word page, or the upper 8 bits a 32-word page.
// - Bus port data is latched, rotated right to the chosen bit, masked, and at most 5 bits add in.
// - The bank_select code 2 picks the left bank and 3 the right bank.
// - A branch_if_nonzero replaces the low counter and address bits when the test is non-zero, else steps on.
// - A register test replaces 8 low bits and a bus field test replaces 5 low bits.
// - A field length code of zero means a full 8-bit field.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ixb_defs.vh"

module ixb_core #(
    parameter ADDR_W = 13
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // avalon-mm slave
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // interface_vector bus banks
    input wire [7:0] ivl_data,
    input wire [7:0] ivr_data,
    // program address outputs
    output reg [ADDR_W-1:0] fetch_addr,
    output reg [ADDR_W-1:0] prog_counter,
    output reg chain_active,
    output reg branch_taken
);
    // pin synchronisers
    reg [7:0] ivl_meta;
    reg [7:0] ivl_sync;
    reg [7:0] ivr_meta;
    reg [7:0] ivr_sync;

    // software visible state
    reg [15:0] instr;
    reg [7:0] operand;
    reg [7:0] iv_latch;

    // decode
    wire [2:0] opcode;
    wire [4:0] src_sel;
    wire [2:0] rotate_position;
    wire [2:0] field_len;
    wire [7:0] lit_reg;
    wire [4:0] lit_bus;
    wire [ADDR_W-1:0] jump_target;
    wire src_is_bus;
    wire [7:0] bus_field;

    // bus cycle control
    wire bus_req;
    wire bus_commit_wr;
    wire exec_now;
    wire pc_wr;
    reg [31:0] rd_value;

    // next state of the address logic
    reg [ADDR_W-1:0] next_pc;
    reg [ADDR_W-1:0] next_ar;
    reg next_chain;
    reg next_taken;
    reg [7:0] next_latch;
    reg [7:0] sum8;
    reg [4:0] sum5;
    reg [ADDR_W-1:0] step_pc;

    function [31:0] merge_bytes;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0] lanes;
        integer i;
        begin
            merge_bytes = old_word;
            for (i = 0; i < 4; i = i + 1) begin
                if (lanes[i]) begin
                    merge_bytes[i*8 +: 8] = new_word[i*8 +: 8];
                end
            end
        end
    endfunction

    assign opcode = instr[`IXB_F_OP_HI:`IXB_F_OP_LO];
    assign src_sel = instr[`IXB_F_SRC_HI:`IXB_F_SRC_LO];
    assign rotate_position = instr[`IXB_F_ROT_HI:`IXB_F_ROT_LO];
    assign field_len = instr[`IXB_F_LEN_HI:`IXB_F_LEN_LO];
    assign lit_reg = instr[`IXB_F_JR_HI:`IXB_F_JR_LO];
    assign lit_bus = instr[`IXB_F_JB_HI:`IXB_F_JB_LO];
    assign jump_target = instr[`IXB_F_JMP_HI:`IXB_F_JMP_LO];

    // source codes with top bit set address the bus banks
    assign src_is_bus = src_sel[4];

    ixb_field u_field (
        .data(iv_latch),
        .rotate_position(rotate_position),
        .length(field_len),
        .field(bus_field)
    );

    assign bus_req = avs_read | avs_write;
    assign bus_commit_wr = avs_write & ~avs_waitrequest;
    // instruction runs on the edge after the word and the latch are in place
    reg exec_pend;
    assign exec_now = exec_pend;
    assign pc_wr = bus_commit_wr & (avs_address == `IXB_OFF_PC);

    // pin synchronisers, first stage read only by the second
    always @(posedge sys_clk) begin
        if (rst) begin
            ivl_meta <= 8'h00;
            ivl_sync <= 8'h00;
            ivr_meta <= 8'h00;
            ivr_sync <= 8'h00;
        end else begin
            ivl_meta <= ivl_data;
            ivl_sync <= ivl_meta;
            ivr_meta <= ivr_data;
            ivr_sync <= ivr_meta;
        end
    end

    // avalon slave: waitrequest drops one cycle after a request appears
    always @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            if (bus_req && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= rd_value;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    always @* begin
        rd_value = 32'h00000000;
        case (avs_address)
            `IXB_OFF_INSTR: rd_value = {16'h0000, instr};
            `IXB_OFF_OPERAND: rd_value = {24'h000000, operand};
            `IXB_OFF_PC: rd_value = {{(32-ADDR_W){1'b0}}, prog_counter};
            `IXB_OFF_AR: rd_value = {{(32-ADDR_W){1'b0}}, fetch_addr};
            `IXB_OFF_STATUS: begin
                rd_value[`IXB_ST_CHAIN] = chain_active;
                rd_value[`IXB_ST_TAKEN] = branch_taken;
                rd_value[`IXB_ST_LATCH_LO +: 8] = iv_latch;
            end
            `IXB_OFF_IVBUS: rd_value = {16'h0000, ivr_sync, ivl_sync};
            default: rd_value = 32'h00000000;
        endcase
    end

    // software registers; an instruction write also latches the port data
    reg [31:0] instr_merged;
    reg [31:0] operand_merged;
    always @* begin
        instr_merged = merge_bytes({16'h0000, instr}, avs_writedata, avs_byteenable);
        operand_merged = merge_bytes({24'h000000, operand}, avs_writedata, avs_byteenable);
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            instr <= `IXB_RST_INSTR;
            operand <= `IXB_RST_OPERAND;
            iv_latch <= 8'h00;
            exec_pend <= 1'b0;
        end else begin
            exec_pend <= 1'b0;
            if (bus_commit_wr && avs_address == `IXB_OFF_INSTR) begin
                instr <= instr_merged[15:0];
                exec_pend <= 1'b1;
                iv_latch <= next_latch;
            end
            if (bus_commit_wr && avs_address == `IXB_OFF_OPERAND) begin
                operand <= operand_merged[7:0];
            end
        end
    end

    // port latch picks the bank named in the incoming word
    always @* begin
        if (instr_merged[`IXB_F_BANK_HI:`IXB_F_BANK_LO] == `IXB_BANK_RIGHT) begin
            next_latch = ivr_sync;
        end else begin
            next_latch = ivl_sync;
        end
    end

    // address computation
    always @* begin
        next_pc = prog_counter;
        next_ar = fetch_addr;
        next_chain = chain_active;
        next_taken = branch_taken;
        step_pc = prog_counter + {{(ADDR_W-1){1'b0}}, 1'b1};
        // carry out dropped, no overflow flag touched
        sum8 = lit_reg + operand;
        // field zero extended, only 5 bits reach the sum
        sum5 = lit_bus + bus_field[4:0];
        if (exec_now) begin
            case (opcode)
                `IXB_OP_XEC: begin
                    // counter held, target fetched next from the new address
                    next_pc = prog_counter;
                    next_chain = 1'b1;
                    next_taken = 1'b0;
                    if (src_is_bus) begin
                        next_ar = {prog_counter[ADDR_W-1:5], sum5};
                    end else begin
                        next_ar = {prog_counter[ADDR_W-1:8], sum8};
                    end
                end
                `IXB_OP_JMP: begin
                    next_pc = jump_target;
                    next_ar = jump_target;
                    next_chain = 1'b0;
                    next_taken = 1'b1;
                end
                `IXB_OP_NZT: begin
                    next_chain = 1'b0;
                    if (src_is_bus ? (bus_field != 8'h00) : (operand != 8'h00)) begin
                        next_taken = 1'b1;
                        if (src_is_bus) begin
                            next_pc = {prog_counter[ADDR_W-1:5], lit_bus};
                        end else begin
                            next_pc = {prog_counter[ADDR_W-1:8], lit_reg};
                        end
                        next_ar = next_pc;
                    end else begin
                        next_taken = 1'b0;
                        next_pc = step_pc;
                        next_ar = step_pc;
                    end
                end
                default: begin
                    // after a chain this returns past the first execute
                    next_pc = step_pc;
                    next_ar = step_pc;
                    next_chain = 1'b0;
                    next_taken = 1'b0;
                end
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            prog_counter <= `IXB_RST_ADDR;
            fetch_addr <= `IXB_RST_ADDR;
            chain_active <= 1'b0;
            branch_taken <= 1'b0;
        end else if (pc_wr) begin
            prog_counter <= avs_writedata[ADDR_W-1:0];
            fetch_addr <= avs_writedata[ADDR_W-1:0];
            chain_active <= 1'b0;
            branch_taken <= 1'b0;
        end else begin
            prog_counter <= next_pc;
            fetch_addr <= next_ar;
            chain_active <= next_chain;
            branch_taken <= next_taken;
        end
    end
endmodule // ixb_core

`default_nettype wire

//--- test/ixb_core_assertions.sv
// port assertions for the program address logic
`timescale 1ns/10ps
`default_nettype none
module ixb_checker #(
    parameter ADDR_W = 13
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // program address
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic [ADDR_W-1:0] prog_counter,
    input wire logic chain_active,
    input wire logic branch_taken
);
    logic [7:0] opnd;
    wire cmt = avs_write && !avs_waitrequest;
    wire ins = cmt && avs_address == 5'h00;
    wire [2:0] op = avs_writedata[15:13];
    wire [7:0] rsum = avs_writedata[7:0] + opnd;
    wire [12:0] pc1 = prog_counter + 13'h0001;
    // shadow of the register-form source operand
    always @(posedge sys_clk) begin
        if (rst) opnd <= 8'h00;
        else if (cmt && avs_address == 5'h04 && avs_byteenable[0]) opnd <= avs_writedata[7:0];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_ins(logic [2:0] o);
        ins && op == o;
    endsequence
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_ack)
        else $error("bus answer slot wrong");
    a_exec_hold: assert property (
        s_ins(3'h4) |-> ##2 prog_counter == $past(prog_counter, 2) && chain_active)
        else $error("counter moved on execute");
    a_reg_sum: assert property (
        s_ins(3'h4) ##0 !avs_writedata[12] |-> ##2
        fetch_addr == {$past(prog_counter[12:8], 2), $past(rsum, 2)})
        else $error("register execute address wrong");
    a_step_one: assert property (
        ins && (op < 3'h4 || op == 3'h6) |-> ##2 prog_counter == $past(pc1, 2)
        && fetch_addr == prog_counter && !chain_active && !branch_taken)
        else $error("sequential step wrong");
    a_jump_load: assert property (
        s_ins(3'h7) |-> ##2 prog_counter == $past(avs_writedata[12:0], 2)
        && fetch_addr == prog_counter && branch_taken)
        else $error("jump load wrong");
    a_nzt_reg: assert property (
        s_ins(3'h5) ##0 !avs_writedata[12] |-> ##2 branch_taken == ($past(opnd, 2) != 8'h00)
        && prog_counter == (branch_taken ? {$past(prog_counter[12:8], 2),
        $past(avs_writedata[7:0], 2)} : $past(pc1, 2)))
        else $error("register branch wrong");
    a_bus_page: assert property (
        s_ins(3'h4) ##0 avs_writedata[12] |-> ##2
        fetch_addr[12:5] == $past(prog_counter[12:5], 2))
        else $error("bus execute page wrong");
    a_pc_load: assert property (cmt && avs_address == 5'h08 |=>
        prog_counter == $past(avs_writedata[12:0]) && fetch_addr == prog_counter
        && !chain_active && !branch_taken)
        else $error("counter load wrong");
endmodule // ixb_checker
`default_nettype wire

//--- test/ixb_port_model.sv
// io ports on both interface_vector banks
`timescale 1ns/10ps
`default_nettype none
module ixb_port_model (
    // clock and bytes to present
    input wire logic sys_clk,
    input wire logic [7:0] left_val,
    input wire logic [7:0] right_val,
    // port pins
    output logic [7:0] ivl_data,
    output logic [7:0] ivr_data
);
    always @(posedge sys_clk) begin
        ivl_data <= left_val;
        ivr_data <= right_val;
    end
endmodule // ixb_port_model
`default_nettype wire

//--- test/tb_indexed_execute_branch_logic.sv
// self-checking bench for the indexed execute and branch logic
`timescale 1ns/10ps
`default_nettype none
module tb_indexed_execute_branch_logic;
    logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, chain_active, branch_taken;
    logic [7:0] left_val = 8'h00, right_val = 8'h00, ivl_data, ivr_data;
    logic [12:0] fetch_addr, prog_counter;
    int error_cnt = 0, total_checks = 0, cycles = 0, i;
    ixb_core #(.ADDR_W(13)) i_ixb_core (.sys_clk(sys_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ivl_data(ivl_data), .ivr_data(ivr_data), .fetch_addr(fetch_addr),
        .prog_counter(prog_counter), .chain_active(chain_active), .branch_taken(branch_taken));
    ixb_port_model i_ixb_port_model (.sys_clk(sys_clk), .left_val(left_val),
        .right_val(right_val), .ivl_data(ivl_data), .ivr_data(ivr_data));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // results land one edge after the instruction write commits
    task automatic run(input logic [15:0] ins);
        bus(1'b1, 5'h00, {16'h0000, ins});
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic expect_pc(input logic [12:0] p, a, input logic c, t);
        chk("prog_counter", {19'h0, p}, {19'h0, prog_counter});
        chk("fetch_addr", {19'h0, a}, {19'h0, fetch_addr});
        chk("chain_active", {31'h0, c}, {31'h0, chain_active});
        chk("branch_taken", {31'h0, t}, {31'h0, branch_taken});
    endtask
    function automatic logic [7:0] fld(input logic [7:0] b, input logic [2:0] r, l);
        logic [15:0] d;
        d = {b, b} >> r;
        return (l == 3'h0) ? d[7:0] : d[7:0] & ~(8'hFF << l);
    endfunction
    task automatic bus_form(input logic [2:0] op, input logic [7:0] lv, rv,
        input logic [1:0] bk, input logic [2:0] ro, ln, input logic [4:0] lt);
        logic [7:0] f;
        logic [4:0] s;
        left_val <= lv;
        right_val <= rv;
        repeat (4) @(posedge sys_clk);
        f = fld(bk == 2'h3 ? rv : lv, ro, ln);
        s = f[4:0] + lt;
        bus(1'b0, 5'h14, 32'h0);
        chk("port sync", {16'h0000, rv, lv}, rd);
        bus(1'b1, 5'h08, 32'h1F40);
        run({op, bk, ro, ln, lt});
        if (op == 3'h4) expect_pc(13'h1F40, {8'hFA, s}, 1'b1, 1'b0);
        else if (f != 8'h00) expect_pc({8'hFA, lt}, {8'hFA, lt}, 1'b0, 1'b1);
        else expect_pc(13'h1F41, 13'h1F41, 1'b0, 1'b0);
        bus(1'b0, 5'h10, 32'h0);
        chk("status", {16'h0000, ((bk == 2'h3) ? rv : lv), 6'h00,
            (op != 3'h4 && f != 8'h00), (op == 3'h4)}, rd);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        expect_pc(13'h0000, 13'h0000, 1'b0, 1'b0);
        bus(1'b0, 5'h18, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, 5'h04, 32'hFE);
        bus(1'b0, 5'h04, 32'h0);
        chk("operand", 32'hFE, rd);
        avs_byteenable <= 4'hE;
        bus(1'b1, 5'h04, 32'h11);
        avs_byteenable <= 4'hF;
        bus(1'b0, 5'h04, 32'h0);
        chk("operand lanes", 32'hFE, rd);
        bus(1'b1, 5'h08, 32'h0123);
        run(16'h8405);
        expect_pc(13'h0123, 13'h0103, 1'b1, 1'b0);
        bus(1'b0, 5'h0C, 32'h0);
        chk("address reg", 32'h0103, rd);
        bus(1'b1, 5'h0C, 32'h1FFF);
        bus(1'b0, 5'h0C, 32'h0);
        chk("address reg held", 32'h0103, rd);
        run(16'h8405);
        run(16'h0000);
        expect_pc(13'h0124, 13'h0124, 1'b0, 1'b0);
        for (i = 0; i < 8; i++) if (i < 4 || i == 6) begin
            bus(1'b1, 5'h08, 32'h1F40);
            run(16'h8401);
            run({i[2:0], 13'h0000});
            expect_pc(13'h1F41, 13'h1F41, 1'b0, 1'b0);
        end
        bus(1'b1, 5'h08, 32'h0200);
        run(16'h8400);
        run(16'hE123);
        expect_pc(13'h0123, 13'h0123, 1'b0, 1'b1);
        bus(1'b1, 5'h08, 32'h0200);
        run(16'hA077);
        expect_pc(13'h0277, 13'h0277, 1'b0, 1'b1);
        bus(1'b1, 5'h04, 32'h00);
        bus(1'b1, 5'h08, 32'h0200);
        run(16'hA077);
        expect_pc(13'h0201, 13'h0201, 1'b0, 1'b0);
        bus_form(3'h4, 8'h36, 8'hC9, 2'h2, 3'h4, 3'h3, 5'h16);
        bus_form(3'h4, 8'h36, 8'hC9, 2'h3, 3'h0, 3'h0, 5'h1F);
        bus_form(3'h4, 8'h00, 8'hFF, 2'h3, 3'h1, 3'h7, 5'h01);
        bus_form(3'h5, 8'h08, 8'h00, 2'h2, 3'h3, 3'h1, 5'h0C);
        bus_form(3'h5, 8'hF7, 8'hFF, 2'h2, 3'h3, 3'h1, 5'h0C);
        bus_form(3'h5, 8'h80, 8'h00, 2'h2, 3'h0, 3'h0, 5'h03);
        give_verdict();
    end
endmodule // tb_indexed_execute_branch_logic
bind ixb_core ixb_checker #(.ADDR_W(ADDR_W)) i_ixb_checker (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest),
    .fetch_addr(fetch_addr), .prog_counter(prog_counter), .chain_active(chain_active),
    .branch_taken(branch_taken));
`default_nettype wire
